// >>> shared/hpss_pkg.sv
// host port serial slave: shared constants, carrier types and state layout
// assumes a 100 MHz system clock; pins arrive from the host clock domain
//
// What this block does
// - host reads and writes device memory via this port, as SPI or I2C slave.
// - stopping the serial clock at any level loses no bits or state.
// - with select low, every 16 clock cycles yield one received 16-bit word.
// - first output bit driven after the later of select fall and clock fall.
// - a select-low period whose clock count is not a multiple of 8 resets the slave.
// - several commands may run back to back within one select-low period.
// - each select rising edge ends the sequence and resets the interface.
// - serial output released whenever deselected, driven only while selected.
// - I2C mode uses the same pins as SPI mode.
// - I2C mode filters out clock and data glitches up to 50 ns wide.
package hpss_pkg;
	localparam int         HPSS_CLK_NS     = 10;
	localparam int         HPSS_GLITCH_NS  = 50;
	// glitch width in system clocks, rounded up so a 50 ns pulse is never taken
	localparam int         HPSS_GLITCH_CYC = (HPSS_GLITCH_NS + HPSS_CLK_NS - 1) / HPSS_CLK_NS;
	localparam int         HPSS_WORD_BITS  = 16;
	localparam int         HPSS_BYTE_BITS  = 8;
	localparam logic [4:0] HPSS_CNT_ZERO   = 5'h00;
	localparam logic [4:0] HPSS_CNT_ONE    = 5'h01;
	localparam logic [4:0] HPSS_CNT_BYTE   = 5'h08;
	localparam logic [4:0] HPSS_CNT_WORD   = 5'h10;
	localparam logic [6:0] HPSS_I2C_ADDR   = 7'h2A; // arbitrary default bus address

	// one received unit handed to the interpreter
	typedef struct packed {
		logic [15:0] data;
		logic        is_byte;
	} hpss_word_t;

	typedef enum logic [2:0] {I2_IDLE, I2_ADDR, I2_AACK, I2_WR, I2_WACK, I2_RD, I2_RACK} hpss_i2c_st_t;

	// whole state of the port
	typedef struct packed {
		logic         clk_q;
		logic         cs_q;
		logic         din_q;
		logic [4:0]   cnt;
		logic         pend;
		logic [15:0]  sh_in;
		logic [15:0]  sh_out;
		logic         oe;
		hpss_word_t   rx;
		logic         rx_valid;
		logic         err;
		logic         load;
		hpss_i2c_st_t ist;
		logic         rw;
		logic         sda_low;
	} hpss_state_t;

	localparam hpss_state_t HPSS_ST_RST = '0;
endpackage : hpss_pkg

// >>> hw/hpss_pin_sync.sv
// host port serial slave: pin synchroniser with glitch filter per pin
// assumes pins are asynchronous to clk; filtered output lags by FILT+3 clocks
`timescale 1ns/1ps
module hpss_pin_sync
	import hpss_pkg::*;
#(
	parameter int WIDTH = 3,
	parameter int FILT  = HPSS_GLITCH_CYC
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_b,
	// raw pins and conditioned copies
	input  wire logic [WIDTH-1:0] pins,
	output logic      [WIDTH-1:0] synced,
	output logic      [WIDTH-1:0] filtered
);
	localparam int CW = $clog2(FILT + 1) + 1;
	localparam logic [CW-1:0] CNT_LIM = CW'(FILT);

	typedef struct packed {
		logic [WIDTH-1:0]         s1;
		logic [WIDTH-1:0]         s2;
		logic [WIDTH-1:0]         filt;
		logic [WIDTH-1:0][CW-1:0] cnt;
	} hpss_sync_st_t;

	hpss_sync_st_t st;
	hpss_sync_st_t next_st;

	// a pin change is taken only once it has stood FILT+1 samples
	always_comb begin
		next_st    = st;
		next_st.s1 = pins;
		next_st.s2 = st.s1; // first stage feeds only this stage
		for (int i = 0; i < WIDTH; i++) begin
			if (st.s2[i] == st.filt[i]) begin
				next_st.cnt[i] = '0;
			end else if (st.cnt[i] == CNT_LIM) begin
				next_st.filt[i] = st.s2[i];
				next_st.cnt[i]  = '0;
			end else begin
				next_st.cnt[i] = st.cnt[i] + CW'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign synced   = st.s2;
	assign filtered = st.filt;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_filter_holds: assert property ((st.s2 == st.filt) |=> $stable(st.filt))
		else $error("filtered pin moved without a standing change");
	a_glitch_short: assert property (($changed(st.filt)) |-> ($past(st.s2, 1) == st.filt))
		else $error("filtered pin took a value not present at the synchroniser");
endmodule : hpss_pin_sync

// >>> hw/hpss_port.sv
// host port serial slave: SPI or I2C slave on one set of host pins
// assumes mode_i2c is static configuration from clk domain; tx_word valid on tx_load
`timescale 1ns/1ps
module hpss_port
	import hpss_pkg::*;
#(
	parameter logic [6:0] I2C_ADDR = HPSS_I2C_ADDR,
	parameter int         FILT     = HPSS_GLITCH_CYC
) (
	// clock and reset
	input  wire logic  clk,
	input  wire logic  rst_b,
	// configuration
	input  wire logic  mode_i2c,
	// host pins; data-in pin doubles as open-drain sda in i2c mode
	input  wire logic  host_clk,
	input  wire logic  host_chip_select_n,
	input  wire logic  host_serial_in,
	output logic       host_serial_in_out,
	output logic       host_serial_in_oe,
	output logic       host_serial_out,
	output logic       host_serial_out_oe,
	// received units toward the interpreter
	output hpss_word_t rx_word,
	output logic       rx_valid,
	output logic       frame_error,
	// reply data from the interpreter
	input  wire logic [15:0] tx_word,
	output logic             tx_load
);
	hpss_state_t st;
	hpss_state_t next_st;
	logic [2:0]  pin_sync;
	logic [2:0]  pin_filt;
	logic        s_clk;
	logic        s_cs;
	logic        s_din;
	logic        clk_rise;
	logic        clk_fall;
	logic        i2c_start;
	logic        i2c_stop;

	// both modes share the same three pins
	hpss_pin_sync #(.WIDTH(3), .FILT(FILT)) u_sync (
		.clk      (clk),
		.rst_b    (rst_b),
		.pins     ({host_serial_in, host_chip_select_n, host_clk}),
		.synced   (pin_sync),
		.filtered (pin_filt)
	);

	// spi uses the fast copy, i2c the glitch-filtered one
	assign s_clk = mode_i2c ? pin_filt[0] : pin_sync[0];
	assign s_cs  = mode_i2c ? pin_filt[1] : pin_sync[1];
	assign s_din = mode_i2c ? pin_filt[2] : pin_sync[2];

	// edges found against the previous sample; no timeout, so a stopped clock waits
	assign clk_rise  = s_clk & ~st.clk_q;
	assign clk_fall  = ~s_clk & st.clk_q;
	assign i2c_start = s_clk & st.clk_q & st.din_q & ~s_din;
	assign i2c_stop  = s_clk & st.clk_q & ~st.din_q & s_din;

	always_comb begin
		next_st          = st;
		next_st.clk_q    = s_clk;
		next_st.cs_q     = s_cs;
		next_st.din_q    = s_din;
		next_st.rx_valid = 1'b0;
		next_st.err      = 1'b0;
		next_st.load     = 1'b0;
		if (!mode_i2c) begin
			next_st.ist     = I2_IDLE;
			next_st.sda_low = 1'b0;
			if (s_cs) begin
				// deselected: output released, framing cleared
				next_st.oe   = 1'b0;
				next_st.cnt  = HPSS_CNT_ZERO;
				next_st.pend = 1'b0;
				if (!st.cs_q) begin
					if (st.cnt == HPSS_CNT_BYTE) begin
						next_st.rx       = '{data: {8'h00, st.sh_in[7:0]}, is_byte: 1'b1};
						next_st.rx_valid = 1'b1;
					end else if (st.cnt != HPSS_CNT_ZERO) begin
						next_st.err = 1'b1; // partial unit dropped, slave back to reset
					end
				end
			end else if (st.cs_q) begin
				// select fell: reply word loaded, drive now only if clock already low
				next_st.sh_out = tx_word;
				next_st.load   = 1'b1;
				next_st.cnt    = HPSS_CNT_ZERO;
				next_st.oe     = ~s_clk;
			end else begin
				if (clk_rise) begin
					next_st.sh_in = {st.sh_in[14:0], s_din};
					if (st.cnt + HPSS_CNT_ONE == HPSS_CNT_WORD) begin
						// a full word; the next one may follow with no gap
						next_st.rx       = '{data: {st.sh_in[14:0], s_din}, is_byte: 1'b0};
						next_st.rx_valid = 1'b1;
						next_st.cnt      = HPSS_CNT_ZERO;
						next_st.pend     = 1'b1;
					end else begin
						next_st.cnt = st.cnt + HPSS_CNT_ONE;
					end
				end
				if (clk_fall) begin
					next_st.oe = 1'b1;
					if (st.pend) begin
						next_st.sh_out = tx_word;
						next_st.load   = 1'b1;
						next_st.pend   = 1'b0;
					end else if (st.cnt != HPSS_CNT_ZERO) begin
						next_st.sh_out = {st.sh_out[14:0], 1'b0};
					end
				end
			end
		end else begin
			// i2c: spi output stays released, chip select is ignored
			next_st.oe = 1'b0;
			if (i2c_start) begin
				next_st.ist     = I2_ADDR;
				next_st.cnt     = HPSS_CNT_ZERO;
				next_st.sda_low = 1'b0;
			end else if (i2c_stop) begin
				next_st.ist     = I2_IDLE;
				next_st.sda_low = 1'b0;
			end else begin
				case (st.ist)
					I2_IDLE: begin
						next_st.cnt = HPSS_CNT_ZERO;
					end
					I2_ADDR, I2_WR: begin
						if (clk_rise) begin
							next_st.sh_in = {st.sh_in[14:0], s_din};
							next_st.cnt   = st.cnt + HPSS_CNT_ONE;
						end else if (clk_fall && st.cnt == HPSS_CNT_BYTE) begin
							next_st.cnt = HPSS_CNT_ZERO;
							if (st.ist == I2_WR) begin
								next_st.rx       = '{data: {8'h00, st.sh_in[7:0]}, is_byte: 1'b1};
								next_st.rx_valid = 1'b1;
								next_st.sda_low  = 1'b1;
								next_st.ist      = I2_WACK;
							end else if (st.sh_in[7:1] == I2C_ADDR) begin
								next_st.rw      = st.sh_in[0];
								next_st.sda_low = 1'b1;
								next_st.ist     = I2_AACK;
							end else begin
								next_st.ist = I2_IDLE; // not our address, stay off the bus
							end
						end
					end
					I2_AACK: begin
						if (clk_fall) begin
							if (st.rw) begin
								// read: low byte of the reply goes out msb first
								next_st.sh_out  = {tx_word[7:0], 8'h00};
								next_st.load    = 1'b1;
								next_st.sda_low = ~tx_word[7];
								next_st.ist     = I2_RD;
							end else begin
								next_st.sda_low = 1'b0;
								next_st.ist     = I2_WR;
							end
						end
					end
					I2_WACK: begin
						if (clk_fall) begin
							next_st.sda_low = 1'b0;
							next_st.ist     = I2_WR;
						end
					end
					I2_RD: begin
						if (clk_rise) begin
							next_st.cnt = st.cnt + HPSS_CNT_ONE;
						end else if (clk_fall) begin
							if (st.cnt == HPSS_CNT_BYTE) begin
								next_st.sda_low = 1'b0; // let the host acknowledge
								next_st.cnt     = HPSS_CNT_ZERO;
								next_st.ist     = I2_RACK;
							end else begin
								next_st.sh_out  = {st.sh_out[14:0], 1'b0};
								next_st.sda_low = ~st.sh_out[14];
							end
						end
					end
					I2_RACK: begin
						// host nack ends the read, ack fetches the next byte
						if (clk_rise) begin
							next_st.ist = s_din ? I2_IDLE : I2_AACK;
						end
					end
					default: begin
						next_st.ist = I2_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st <= HPSS_ST_RST;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from state flops, except the sda drive value tied low
	assign host_serial_out    = st.sh_out[15];
	assign host_serial_out_oe = st.oe;
	assign host_serial_in_out = 1'b0;           // open drain: only ever pulls low
	assign host_serial_in_oe  = st.sda_low;
	assign rx_word            = st.rx;
	assign rx_valid           = st.rx_valid;
	assign frame_error        = st.err;
	assign tx_load            = st.load;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_oe_deselect: assert property ((!mode_i2c && s_cs) |=> !host_serial_out_oe)
		else $error("serial output driven while deselected");
	a_first_bit_wait: assert property ((!mode_i2c && !s_cs && st.cs_q && s_clk) |=> !host_serial_out_oe)
		else $error("output enabled before clock fell");
	a_word_sixteen: assert property ((!mode_i2c && !s_cs && !st.cs_q && clk_rise && st.cnt == 5'h0F)
		|=> (rx_valid && !rx_word.is_byte))
		else $error("sixteenth clock did not deliver a word");
	a_byte_close: assert property ((!mode_i2c && s_cs && !st.cs_q && st.cnt == HPSS_CNT_BYTE)
		|=> (rx_valid && rx_word.is_byte))
		else $error("eight clock frame did not deliver a byte");
	a_bad_length: assert property ((!mode_i2c && s_cs && !st.cs_q && st.cnt != HPSS_CNT_BYTE
		&& st.cnt != HPSS_CNT_ZERO) |=> (frame_error && !rx_valid))
		else $error("odd frame length not flagged");
	a_rise_resets: assert property ((!mode_i2c && s_cs && !st.cs_q) |=> (st.cnt == HPSS_CNT_ZERO && !st.pend)
		##1 (st.cnt == HPSS_CNT_ZERO))
		else $error("select rise did not reset framing");
	a_clock_parked: assert property ((!mode_i2c && !s_cs && !st.cs_q && s_clk == st.clk_q)
		|=> ($stable(st.cnt) && $stable(st.sh_in)))
		else $error("state changed with clock stopped");
	a_i2c_pins: assert property (mode_i2c |=> !host_serial_out_oe)
		else $error("spi output driven in i2c mode");

	c_word_rx: cover property (rx_valid && !rx_word.is_byte);
	c_byte_rx: cover property (rx_valid && rx_word.is_byte && !mode_i2c);
	c_back_to_back: cover property ((rx_valid && !s_cs) ##[1:200] (rx_valid && !s_cs));
	c_i2c_write: cover property (mode_i2c && rx_valid);
endmodule : hpss_port

// >>> test/hpss_host_model.sv
// host side model of the serial slave port: spi master and i2c master on shared pins
// assumes the bench resolves sda as open drain with pull-up and shows miso as z when released
`timescale 1ns/1ps
module hpss_host_model
	import hpss_pkg::*;
#(
	parameter int HALF_NS     = 80,
	parameter int I2C_HALF_NS = 1250
) (
	// host driven pins
	output logic      sck,
	output logic      cs_n,
	output logic      mosi,
	output logic      sda_low,
	// pins as the host sees them
	input  wire logic miso,
	input  wire logic miso_oe,
	input  wire logic sda
);
	// spi idle: clock at rest low, deselected
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
		sda_low = 1'b0;
	end

	// first rise waits past output enable delay plus setup
	task automatic sel();
		#3;
		cs_n = 1'b0;
		#200;
	endtask : sel

	// select stays high far beyond 61 ns before any new frame
	task automatic desel();
		#HALF_NS;
		cs_n = 1'b1;
		mosi = ~mosi; // released data line shows no stale value
		#150;
	endtask : desel

	// n bits msb first at 160 ns period, within the 25 MHz limit stall halts clock high then low
	task automatic bits(input logic [15:0] d, input int n, input int stall, output logic [15:0] q);
		q = 16'h0000;
		for (int i = n - 1; i >= 0; i--) begin
			mosi = d[i];
			#HALF_NS;
			sck = 1'b1;
			q = {q[14:0], (miso_oe === 1'b1) ? miso : 1'bx};
			if (i == 9) #stall;
			#HALF_NS;
			sck = 1'b0;
			if (i == 4) #stall;
		end
	endtask : bits

	// i2c bus idle: both lines high
	task automatic i2c_idle();
		sck = 1'b1;
		sda_low = 1'b0;
	endtask : i2c_idle

	task automatic i2c_start();
		sda_low = 1'b1;
		#I2C_HALF_NS;
		sck = 1'b0;
	endtask : i2c_start

	// one byte plus ack slot at 400 kHz glitch puts a 40 ns dip on scl mid high
	task automatic i2c_byte(input logic [7:0] d, input bit glitch, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			#(I2C_HALF_NS / 2);
			sda_low = (i > 0) ? ~d[(i + 7) % 8] : 1'b0;
			#(I2C_HALF_NS / 2);
			sck = 1'b1;
			#(I2C_HALF_NS / 2);
			if (glitch && i == 4) sck = 1'b0;
			if (glitch && i == 4) #40 sck = 1'b1;
			ack = sda;
			#(I2C_HALF_NS / 2);
			sck = 1'b0;
		end
	endtask : i2c_byte

	task automatic i2c_stop();
		sda_low = 1'b1;
		#I2C_HALF_NS;
		sck = 1'b1;
		#I2C_HALF_NS;
		sda_low = 1'b0;
		#I2C_HALF_NS;
	endtask : i2c_stop
endmodule : hpss_host_model

// >>> test/hpss_port_tb.sv
// self-checking bench of the host port: spi frames of words, bytes and bad counts, then i2c writes
// assumes the host model above; rx pulses are queued by a monitor and popped by the scenarios
`timescale 1ns/1ps
module hpss_port_tb;
	import hpss_pkg::*;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        mode_i2c = 1'b0;
	logic        sck, cs_n, mosi, sda_low, out, out_oe, sda_oe, rx_valid, frame_error, tx_load, ack;
	logic [7:0]  tx_idx = 8'h00;
	logic [15:0] tx_word, q0, q1;
	hpss_word_t  rx_word, w;
	hpss_word_t  rx_q[$];
	int          num_errors = 0;
	int          num_checks = 0;
	int          n_ferr = 0;
	// open-drain sda with pull-up; spi data-in otherwise
	wire sda = ~(sda_low | sda_oe);
	wire din = mode_i2c ? sda : mosi;
	wire miso = out_oe ? out : 1'bz;
	assign tx_word = {tx_idx ^ 8'h5A, ~tx_idx};

	always #5 clk = ~clk;

	hpss_port uut (.clk(clk), .rst_b(rst_b), .mode_i2c(mode_i2c), .host_clk(sck), .host_chip_select_n(cs_n),
		.host_serial_in(din), .host_serial_in_out(), .host_serial_in_oe(sda_oe), .host_serial_out(out),
		.host_serial_out_oe(out_oe), .rx_word(rx_word), .rx_valid(rx_valid), .frame_error(frame_error),
		.tx_word(tx_word), .tx_load(tx_load));
	hpss_host_model host (.sck(sck), .cs_n(cs_n), .mosi(mosi), .sda_low(sda_low), .miso(miso),
		.miso_oe(out_oe), .sda(sda));

	// pulse monitor; reply index steps after each capture so the next word is ready in time
	always @(posedge clk) begin
		if (rx_valid === 1'b1) rx_q.push_back(rx_word);
		if (frame_error === 1'b1) n_ferr++;
		if (tx_load === 1'b1) tx_idx <= #1 tx_idx + 8'h01;
	end

	function automatic logic [15:0] reply(input logic [7:0] k);
		return {k ^ 8'h5A, ~k};
	endfunction : reply

	task automatic check(input logic [16:0] seen, input logic [16:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic stop_test();
		if (num_errors == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : stop_test

	// bounded wait for one received unit
	task automatic get_rx(output hpss_word_t r);
		for (int i = 0; i < 20 && rx_q.size() == 0; i++) @(posedge clk);
		if (rx_q.size() == 0) num_errors++;
		if (rx_q.size() == 0) stop_test();
		r = rx_q.pop_front();
	endtask : get_rx

	task automatic do_reset(input logic m);
		@(posedge clk);
		#1 rst_b = 1'b0;
		mode_i2c = m;
		repeat (4) @(posedge clk);
		#1 rst_b = 1'b1;
		repeat (12) @(posedge clk);
		rx_q.delete();
		n_ferr = 0;
	endtask : do_reset

	// one word, optionally with the clock halted high and low for a long time
	task automatic t_word(input logic [15:0] d, input int stall);
		logic [7:0] i0;
		int         f0;
		i0 = tx_idx;
		f0 = n_ferr; // error pulses of earlier frames are not this frame's
		check(out_oe, 1'b0);
		host.sel();
		host.bits(d, 16, stall, q0);
		host.desel();
		check(out_oe, 1'b0);
		get_rx(w);
		check(w, {d, 1'b0});
		check(q0, reply(i0));
		check(17'(n_ferr), 17'(f0));
	endtask : t_word

	// two words back to back under one select
	task automatic t_multi();
		logic [7:0] i0;
		i0 = tx_idx;
		host.sel();
		host.bits(16'h8001, 16, 0, q0);
		host.bits(16'h7FFE, 16, 0, q1); // select held low between words
		host.desel();
		get_rx(w);
		check(w, {16'h8001, 1'b0});
		get_rx(w);
		check(w, {16'h7FFE, 1'b0});
		check({q0, 1'b0}, {reply(i0), 1'b0});
		check(q1, reply(i0 + 8'h01));
	endtask : t_multi

	// byte frame accepted, then a five-clock frame dropped with an error
	task automatic t_count();
		logic [7:0] i0;
		i0 = tx_idx;
		host.sel();
		host.bits(16'h00B7, 8, 0, q0);
		host.desel();
		get_rx(w);
		check(w, {16'h00B7, 1'b1});
		check(q0[7:0], reply(i0) >> 8);
		host.sel();
		host.bits(16'h0015, 5, 0, q0);
		host.desel();
		check(17'(n_ferr), 17'h00001);
		check(rx_q.size(), 0);
	endtask : t_count

	// i2c write on the same pins with an scl glitch, then a foreign address left unanswered
	task automatic t_i2c();
		host.i2c_start();
		host.i2c_byte({HPSS_I2C_ADDR, 1'b0}, 1'b0, ack);
		check(ack, 1'b0);
		host.i2c_byte(8'h96, 1'b1, ack);
		check(ack, 1'b0);
		host.i2c_stop();
		get_rx(w);
		check(w, {16'h0096, 1'b1});
		host.i2c_start();
		host.i2c_byte({~HPSS_I2C_ADDR, 1'b0}, 1'b0, ack);
		check(ack, 1'b1);
		host.i2c_stop();
		check(rx_q.size(), 0);
	endtask : t_i2c

	// main sequence
	initial begin
		do_reset(1'b0);
		t_word(16'hC35A, 0);
		t_multi();
		t_count();
		t_word(16'h0FF0, 0); // clean word after the error frame shows the reset
		t_word(16'h1234, 20000);
		host.i2c_idle();
		do_reset(1'b1);
		t_i2c();
		stop_test();
	end
endmodule : hpss_port_tb
